// [itm_misalign.sv]
/*
 * Splits one operand reference into aligned internal core bus accesses and
 * gives the extra cost of a misaligned one. Pure combinational; assumes the
 * caller supplies the two low address bits and the operand size.
 */
`timescale 1ns/10ps
`default_nettype none

module itm_misalign
(
    input wire itm_pkg::itm_size_e size,
    input wire logic [1:0] addr_low,
    input wire logic is_write,
    input wire logic active,
    output logic misaligned,
    output itm_pkg::itm_split_s split,
    output itm_pkg::itm_cost_s extra
);

    // Alignment classes; bytes are always aligned.
    wire odd_addr;
    wire half_addr;
    wire word_odd;
    wire long_odd;
    wire long_half;

    assign odd_addr = addr_low[itm_pkg::ITM_ODD_BIT];
    assign half_addr = addr_low == itm_pkg::ITM_ADDR_HALF;
    assign word_odd = active && size == itm_pkg::ITM_SZ_WORD && odd_addr;
    assign long_odd = active && size == itm_pkg::ITM_SZ_LONG && odd_addr;
    assign long_half = active && size == itm_pkg::ITM_SZ_LONG && half_addr;
    assign misaligned = word_odd || long_odd || long_half;

    // Access sequence: byte-byte, byte-word-byte or word-word.
    always_comb
    begin
        split = '{itm_pkg::ITM_BUS_NONE, itm_pkg::ITM_BUS_NONE, itm_pkg::ITM_BUS_NONE};
        if (word_odd)
        begin
            split = '{itm_pkg::ITM_BUS_BYTE, itm_pkg::ITM_BUS_BYTE,
                      itm_pkg::ITM_BUS_NONE};
        end
        else if (long_odd)
        begin
            split = '{itm_pkg::ITM_BUS_BYTE, itm_pkg::ITM_BUS_WORD,
                      itm_pkg::ITM_BUS_BYTE};
        end
        else if (long_half)
        begin
            split = '{itm_pkg::ITM_BUS_WORD, itm_pkg::ITM_BUS_WORD,
                      itm_pkg::ITM_BUS_NONE};
        end
        else if (active)
        begin
            split.first = (size == itm_pkg::ITM_SZ_BYTE) ? itm_pkg::ITM_BUS_BYTE :
                          (size == itm_pkg::ITM_SZ_WORD) ? itm_pkg::ITM_BUS_WORD :
                          itm_pkg::ITM_BUS_LONG;
        end
    end

    // Extra cost of the split, read and write figures differ.
    always_comb
    begin
        extra = '{itm_pkg::ITM_CYC_RESET, itm_pkg::ITM_N0, itm_pkg::ITM_N0};
        if (long_odd && is_write)
        begin
            extra = '{itm_pkg::ITM_C2, itm_pkg::ITM_N0, itm_pkg::ITM_N2};
        end
        else if (long_odd)
        begin
            extra = '{itm_pkg::ITM_C3, itm_pkg::ITM_N2, itm_pkg::ITM_N0};
        end
        else if ((word_odd || long_half) && is_write)
        begin
            extra = '{itm_pkg::ITM_C1, itm_pkg::ITM_N0, itm_pkg::ITM_N1};
        end
        else if (word_odd || long_half)
        begin
            extra = '{itm_pkg::ITM_C2, itm_pkg::ITM_N1, itm_pkg::ITM_N0};
        end
    end

endmodule // itm_misalign

`default_nettype wire

// [itm_pkg.sv]
/*
 * Shared types and constants for the instruction timing model of the operand
 * execution pipeline. Assumes a single 40 MHz core clock and no software
 * visible registers.
 */
package itm_pkg;

    // Effective addressing mode classes, as seen by the timing model.
    typedef enum logic [3:0] {
        ITM_EA_DREG,
        ITM_EA_AREG,
        ITM_EA_IND,
        ITM_EA_POSTINC,
        ITM_EA_PREDEC,
        ITM_EA_DISP16,
        ITM_EA_INDEX,
        ITM_EA_ABS_W,
        ITM_EA_ABS_L,
        ITM_EA_PC_DISP16,
        ITM_EA_PC_INDEX,
        ITM_EA_IMM
    } itm_ea_e;

    // Operand sizes.
    typedef enum logic [1:0] {
        ITM_SZ_BYTE,
        ITM_SZ_WORD,
        ITM_SZ_LONG
    } itm_size_e;

    // Internal core bus access sizes for the split of an operand reference.
    typedef enum logic [1:0] {
        ITM_BUS_NONE,
        ITM_BUS_BYTE,
        ITM_BUS_WORD,
        ITM_BUS_LONG
    } itm_bus_e;

    // One timing entry C(r/w).
    typedef struct packed {
        logic [5:0] cycles;
        logic [1:0] reads;
        logic [1:0] writes;
    } itm_cost_s;

    // An instruction offered to the operand execution pipeline.
    typedef struct packed {
        itm_ea_e src;
        itm_ea_e dst;
        itm_size_e size;
        logic is_multi_move;
        logic [1:0] src_addr_low;
        logic [1:0] dst_addr_low;
    } itm_instr_s;

    // Up to three aligned accesses for one operand reference.
    typedef struct packed {
        itm_bus_e first;
        itm_bus_e second;
        itm_bus_e third;
    } itm_split_s;

    localparam int ITM_CLK_MHZ = 40;
    localparam int ITM_BUSY_WINDOW = 2;
    localparam logic [1:0] ITM_BUSY_LOAD = 2'h2;
    localparam logic [1:0] ITM_ADDR_HALF = 2'h2;
    localparam int ITM_ODD_BIT = 0;
    localparam logic [5:0] ITM_C1 = 6'h01;
    localparam logic [5:0] ITM_C2 = 6'h02;
    localparam logic [5:0] ITM_C3 = 6'h03;
    localparam logic [5:0] ITM_C4 = 6'h04;
    localparam logic [1:0] ITM_N0 = 2'h0;
    localparam logic [1:0] ITM_N1 = 2'h1;
    localparam logic [1:0] ITM_N2 = 2'h2;
    localparam logic [5:0] ITM_CYC_RESET = 6'h00;

endpackage

// [itm_timing.sv]
/*
 * Timing model of the operand execution pipeline for move instructions.
 * An instruction is offered with its addressing modes, size and low address
 * bits; the block works out its C(r/w) cost, runs it cycle by cycle and
 * enforces the store-to-store busy window. Assumes the instruction arrives
 * fully decoded with all extension words (no fetch waits) and that operand
 * memory never adds wait states.
 */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Cost given as cycles plus reads/writes.
// - Cycle total covers accesses and internal cycles.
// - Non-multi-move store busies resources two cycles.
// - Later store stalls inside window, max two.
// - Multi-register move ignores the busy window.
// - Word aligned mod 2, long mod 4.
// - Misaligned splits into aligned bus accesses.
// - Misaligned accesses add documented extra cost.
// - PC-relative modes time like An-relative.
// - Short and long absolute time alike.
// - Register-source byte/word move costs.
// - Memory-source byte/word move costs.
// - Immediate byte/word move costs.
// - Long move costs from memory or register.
// - Immediate long move costs.
// - No waiting on instruction fetch pipeline.
module itm_timing
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire itm_pkg::itm_instr_s issue,
    output logic busy,
    output logic store_stall,
    output logic resources_busy,
    output logic unsupported,
    output logic done,
    output itm_pkg::itm_cost_s done_cost,
    output itm_pkg::itm_split_s src_split,
    output itm_pkg::itm_split_s dst_split
);

    typedef enum logic [1:0] {
        ITM_IDLE,
        ITM_RUN
    } itm_state_e;

    // Class helpers; PC-relative folds onto An-relative and both absolute
    // forms fold together, so the tables need only one column each.
    function automatic logic is_reg(input itm_pkg::itm_ea_e ea);
        return ea == itm_pkg::ITM_EA_DREG || ea == itm_pkg::ITM_EA_AREG;
    endfunction

    function automatic logic is_index(input itm_pkg::itm_ea_e ea);
        return ea == itm_pkg::ITM_EA_INDEX || ea == itm_pkg::ITM_EA_PC_INDEX;
    endfunction

    function automatic logic is_disp(input itm_pkg::itm_ea_e ea);
        return ea == itm_pkg::ITM_EA_DISP16 || ea == itm_pkg::ITM_EA_PC_DISP16;
    endfunction

    function automatic logic is_abs(input itm_pkg::itm_ea_e ea);
        return ea == itm_pkg::ITM_EA_ABS_W || ea == itm_pkg::ITM_EA_ABS_L;
    endfunction

    function automatic logic is_simple(input itm_pkg::itm_ea_e ea);
        return ea == itm_pkg::ITM_EA_IND || ea == itm_pkg::ITM_EA_POSTINC ||
               ea == itm_pkg::ITM_EA_PREDEC;
    endfunction

    itm_state_e state;
    logic [5:0] cycles_left;
    logic [1:0] busy_count;
    itm_pkg::itm_cost_s run_cost;
    logic run_store;
    logic run_multi;

    wire itm_pkg::itm_ea_e src;
    wire itm_pkg::itm_ea_e dst;
    wire is_long;
    wire src_reg;
    wire src_imm;
    wire src_mem;
    wire dst_reg;
    wire dst_mem;
    wire dst_idx;
    wire dst_legal;
    wire src_legal;
    wire pair_legal;
    wire is_store;
    wire window_hit;
    wire accept;
    wire src_mis;
    wire dst_mis;
    itm_pkg::itm_cost_s base_cost;
    itm_pkg::itm_cost_s src_extra;
    itm_pkg::itm_cost_s dst_extra;
    itm_pkg::itm_cost_s total_cost;

    assign src = issue.src;
    assign dst = issue.dst;
    assign is_long = issue.size == itm_pkg::ITM_SZ_LONG;
    assign src_reg = is_reg(src);
    assign src_imm = src == itm_pkg::ITM_EA_IMM;
    assign src_mem = !src_reg && !src_imm;
    assign dst_reg = is_reg(dst);
    assign dst_idx = dst == itm_pkg::ITM_EA_INDEX;
    assign dst_mem = !dst_reg;

    // Legal pairs: destinations cannot be PC-relative or immediate; indexed,
    // absolute and immediate sources limit the destination set.
    assign dst_legal = dst_reg || is_simple(dst) || dst == itm_pkg::ITM_EA_DISP16 ||
                       dst_idx || is_abs(dst);
    assign src_legal = src_reg || src_imm || is_simple(src) || is_disp(src) ||
                       is_index(src) || is_abs(src);
    assign pair_legal = dst_legal && src_legal &&
        (src_reg || (is_simple(src) && 1'b1) ||
         (is_disp(src) && !dst_idx && !is_abs(dst)) ||
         ((is_index(src) || is_abs(src) || src_imm) && (dst_reg || is_simple(dst))));

    // Base table cost; memory-source and immediate-to-memory entries sized by operand length.
    always_comb
    begin
        base_cost = '{itm_pkg::ITM_C1, itm_pkg::ITM_N0, itm_pkg::ITM_N0};
        if (src_reg)
        begin
            base_cost.cycles = dst_idx ? itm_pkg::ITM_C2 : itm_pkg::ITM_C1;
            base_cost.writes = dst_mem ? itm_pkg::ITM_N1 : itm_pkg::ITM_N0;
        end
        else if (src_imm)
        begin
            base_cost.cycles = dst_reg ? itm_pkg::ITM_C1 :
                               (is_long ? itm_pkg::ITM_C2 : itm_pkg::ITM_C3);
            base_cost.writes = dst_mem ? itm_pkg::ITM_N1 : itm_pkg::ITM_N0;
        end
        else
        begin
            base_cost.reads = itm_pkg::ITM_N1;
            base_cost.writes = dst_mem ? itm_pkg::ITM_N1 : itm_pkg::ITM_N0;
            if (is_index(src) || dst_idx)
            begin
                base_cost.cycles = is_long ? itm_pkg::ITM_C3 : itm_pkg::ITM_C4;
            end
            else
            begin
                base_cost.cycles = is_long ? itm_pkg::ITM_C2 : itm_pkg::ITM_C3;
            end
        end
    end

    // Misaligned source reads and destination writes add their own cost.
    itm_misalign u_src_mis
    (
        .size(issue.size),
        .addr_low(issue.src_addr_low),
        .is_write(1'b0),
        .active(src_mem),
        .misaligned(src_mis),
        .split(src_split),
        .extra(src_extra)
    );

    itm_misalign u_dst_mis
    (
        .size(issue.size),
        .addr_low(issue.dst_addr_low),
        .is_write(1'b1),
        .active(dst_mem),
        .misaligned(dst_mis),
        .split(dst_split),
        .extra(dst_extra)
    );

    // Total C(r/w); a read-modify-write shows as one read plus one write.
    assign total_cost.cycles = 6'(base_cost.cycles + src_extra.cycles + dst_extra.cycles);
    assign total_cost.reads = 2'(base_cost.reads + src_extra.reads);
    assign total_cost.writes = 2'(base_cost.writes + dst_extra.writes);

    // A store here is any move with a memory destination. The multi-register
    // move uses other resources, so it neither waits nor arms the window.
    assign is_store = dst_mem && !issue.is_multi_move;
    assign window_hit = is_store && busy_count != 2'h0;
    assign resources_busy = busy_count != 2'h0;
    assign unsupported = issue_valid && !pair_legal;

    // A legal issue is taken at once when idle unless a store hits the busy window; no fetch wait is modelled.
    assign issue_ready = state == ITM_IDLE && !window_hit;
    assign store_stall = issue_valid && state == ITM_IDLE && pair_legal && window_hit;
    assign accept = issue_valid && issue_ready && pair_legal;
    assign busy = state == ITM_RUN;

    // Execution sequencer; one state per instruction, counted in cycles.
    // Memory is assumed zero-wait, so no access ever extends a cycle.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= ITM_IDLE;
            cycles_left <= itm_pkg::ITM_CYC_RESET;
            run_cost <= '{itm_pkg::ITM_CYC_RESET, itm_pkg::ITM_N0, itm_pkg::ITM_N0};
            run_store <= 1'b0;
            run_multi <= 1'b0;
        end
        else
        begin
            unique case (state)
                ITM_IDLE:
                begin
                    if (accept)
                    begin
                        state <= ITM_RUN;
                        cycles_left <= total_cost.cycles;
                        run_cost <= total_cost;
                        run_store <= dst_mem;
                        run_multi <= issue.is_multi_move;
                    end
                end
                ITM_RUN:
                begin
                    cycles_left <= 6'(cycles_left - 6'h01);
                    if (cycles_left == 6'h01)
                    begin
                        state <= ITM_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy window: loaded after the final store cycle, counts down to zero.
    // A stalled store therefore waits at most two cycles.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            busy_count <= 2'h0;
        end
        else if (state == ITM_RUN && cycles_left == 6'h01 && run_store && !run_multi)
        begin
            busy_count <= itm_pkg::ITM_BUSY_LOAD;
        end
        else if (busy_count != 2'h0)
        begin
            busy_count <= 2'(busy_count - 2'h1);
        end
    end

    // Completion report, held one cycle with the cost it ran.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            done <= 1'b0;
            done_cost <= '{itm_pkg::ITM_CYC_RESET, itm_pkg::ITM_N0, itm_pkg::ITM_N0};
        end
        else
        begin
            done <= state == ITM_RUN && cycles_left == 6'h01;
            done_cost <= run_cost;
        end
    end

endmodule // itm_timing

`default_nettype wire

// [itm_timing_props.sv]
/*
 * Concurrent checks on the ports of the move timing block.
 * Assumes one clock domain and a synchronous active high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module itm_timing_props
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire itm_pkg::itm_instr_s issue,
    input wire logic busy,
    input wire logic store_stall,
    input wire logic resources_busy,
    input wire logic unsupported,
    input wire logic done,
    input wire itm_pkg::itm_cost_s done_cost,
    input wire itm_pkg::itm_split_s src_split,
    input wire itm_pkg::itm_split_s dst_split
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // An accepted legal instruction, and whether its destination is memory.
    wire logic take = issue_valid && issue_ready && !unsupported;
    wire logic to_mem = !(issue.dst inside {itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_AREG});

    // Completion, window length and stall bounds.
    a_done_at_end: assert property ($fell(busy) |-> done)
        else $error("done not raised as busy fell");
    a_busy_not_ready: assert property (busy |-> !issue_ready)
        else $error("ready while busy");
    a_window_two: assert property ($rose(resources_busy) |=> resources_busy ##1 !resources_busy)
        else $error("busy window not two cycles");
    a_stall_max_two: assert property (store_stall |-> ##[1:2] !store_stall)
        else $error("store stall longer than two cycles");
    a_store_stalls: assert property (resources_busy && issue_valid && !busy && !unsupported
        && !issue.is_multi_move && to_mem |-> store_stall && !issue_ready)
        else $error("store not held in busy window");
    a_multi_no_stall: assert property (issue_valid && issue.is_multi_move && !busy
        && !unsupported |-> !store_stall && issue_ready)
        else $error("multi register move stalled");
    a_reg_move_cost: assert property (take && issue.src == itm_pkg::ITM_EA_DREG
        && issue.dst == itm_pkg::ITM_EA_DREG |=> busy ##1 (done && done_cost == 10'h010))
        else $error("register move cost wrong");
    a_long_mem_cost: assert property (take && issue.src == itm_pkg::ITM_EA_IND
        && issue.dst == itm_pkg::ITM_EA_IND && issue.size == itm_pkg::ITM_SZ_LONG
        && issue.src_addr_low == 2'h0 && issue.dst_addr_low == 2'h0
        |-> ##3 done && done_cost == 10'h025)
        else $error("long memory move cost wrong");
    a_odd_long_split: assert property (issue_valid && issue.src == itm_pkg::ITM_EA_IND
        && issue.size == itm_pkg::ITM_SZ_LONG && issue.src_addr_low == 2'h1
        |-> src_split == 6'h19)
        else $error("odd long split wrong");
    a_unsup_ignored: assert property (unsupported && !busy |=> !busy)
        else $error("unsupported pair started");

    // Main scenarios reached.
    c_stall: cover property (store_stall);
    c_window: cover property ($rose(resources_busy));
    c_misaligned: cover property (done && done_cost.reads == 2'h3);
endmodule // itm_timing_props

bind itm_timing itm_timing_props itm_timing_props_inst (.sys_clk, .reset, .issue_valid,
    .issue_ready, .issue, .busy, .store_stall, .resources_busy, .unsupported, .done,
    .done_cost, .src_split, .dst_split);

`default_nettype wire

// [itm_zero_wait_mem.sv]
/*
 * Model of the operand memory on the internal core bus.
 * Assumes the timing block exposes only its busy flag; every access is
 * answered in the cycle it is made.
 */
`timescale 1ns/10ps
`default_nettype none

module itm_zero_wait_mem
(
    input wire logic busy,
    output logic mem_ack
);
    // Answering in the same cycle means the memory never inserts a wait state.
    assign mem_ack = busy;
endmodule // itm_zero_wait_mem

`default_nettype wire

// [tb_itm_timing.sv]
/*
 * Self-checking bench for the move timing block.
 * Assumes a 40 MHz clock, inputs driven 1 ns after the rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_itm_timing;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic issue_valid = 1'b0;
    itm_pkg::itm_instr_s issue = '0;
    logic issue_ready, busy, store_stall, resources_busy, unsupported, done, mem_ack;
    itm_pkg::itm_cost_s done_cost;
    itm_pkg::itm_split_s src_split, dst_split;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    itm_timing itm_timing_inst (.sys_clk, .reset, .issue_valid, .issue_ready, .issue, .busy,
        .store_stall, .resources_busy, .unsupported, .done, .done_cost, .src_split, .dst_split);
    itm_zero_wait_mem itm_zero_wait_mem_inst (.busy, .mem_ack);

    // Clock and a hang guard far above the hundred or fewer cycles the run needs.
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_n(input string what, input int exp, input int got);
        checks++;
        if (got != exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Sizes are passed as codes: 0 byte, 1 word, 2 long.
    function automatic itm_pkg::itm_instr_s mk(itm_pkg::itm_ea_e s, d, logic [1:0] z,
        logic m, logic [1:0] sa, da);
        return '{s, d, itm_pkg::itm_size_e'(z), m, sa, da};
    endfunction

    task automatic wait_done(output int c);
        c = 0;
        while (done !== 1'b1 && c < 70)
        begin
            @(posedge sys_clk);
            #1;
            c++;
        end
    endtask

    // Offers one move, holds it until taken, then checks latency and cost.
    // A split of zero skips the split check; splits are packed 2-bit bus codes.
    task automatic run(input itm_pkg::itm_instr_s ins, input logic [9:0] exp,
        input logic [5:0] sp, output int waited);
        int c;
        issue = ins;
        issue_valid = 1'b1;
        waited = 0;
        #1;
        if (sp != 6'h00)
            chk("split", sp, src_split | dst_split);
        while (issue_ready !== 1'b1 && waited < 20)
        begin
            @(posedge sys_clk);
            #1;
            waited++;
        end
        @(posedge sys_clk);
        #1 issue_valid = 1'b0;
        chk("memory ack", 1'b1, mem_ack);
        wait_done(c);
        chk_n("latency", exp[9:4], c);
        chk("cost", exp, done_cost);
    endtask

    task automatic t_reset;
        chk("ready", 1'b1, issue_ready);
        chk("window", 1'b0, resources_busy);
    endtask

    // Byte, word and long moves across the source and destination classes.
    task automatic t_moves;
        run(mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_DREG, 2'h0, 0, 0, 0), 10'h010, 0, n);
        run(mk(itm_pkg::ITM_EA_AREG, itm_pkg::ITM_EA_INDEX, 2'h1, 0, 0, 0), 10'h021, 0, n);
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_DREG, 2'h1, 0, 0, 0), 10'h034, 0, n);
        run(mk(itm_pkg::ITM_EA_INDEX, itm_pkg::ITM_EA_IND, 2'h0, 0, 0, 0), 10'h045, 0, n);
        run(mk(itm_pkg::ITM_EA_IMM, itm_pkg::ITM_EA_POSTINC, 2'h1, 0, 0, 0), 10'h031, 0, n);
        run(mk(itm_pkg::ITM_EA_PC_INDEX, itm_pkg::ITM_EA_PREDEC, 2'h1, 0, 0, 0), 10'h045, 0, n);
        run(mk(itm_pkg::ITM_EA_ABS_W, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 0), 10'h025, 0, n);
        run(mk(itm_pkg::ITM_EA_ABS_L, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 0), 10'h025, 0, n);
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 0), 10'h025, 0, n);
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_INDEX, 2'h2, 0, 0, 0), 10'h035, 0, n);
        run(mk(itm_pkg::ITM_EA_IMM, itm_pkg::ITM_EA_PREDEC, 2'h2, 0, 0, 0), 10'h021, 0, n);
    endtask

    // Misaligned references add their extra cost on top of the table entry.
    task automatic t_misalign;
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_DREG, 2'h1, 0, 1, 0), 10'h058, 6'h14, n);
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_DREG, 2'h2, 0, 1, 0), 10'h05C, 6'h19, n);
        run(mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 2), 10'h022, 6'h28, n);
        run(mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 3), 10'h033, 6'h19, n);
        run(mk(itm_pkg::ITM_EA_IND, itm_pkg::ITM_EA_DREG, 2'h1, 0, 2, 0), 10'h034, 0, n);
    endtask

    // Store after store waits out the window; multi register moves never do.
    task automatic t_stall;
        run(mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_IND, 2'h2, 0, 0, 0), 10'h011, 0, n);
        run(mk(itm_pkg::ITM_EA_AREG, itm_pkg::ITM_EA_POSTINC, 2'h1, 0, 0, 0), 10'h011, 0, n);
        chk_n("store wait", 2, n);
        issue = mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_IND, 2'h2, 1, 0, 0);
        issue_valid = 1'b1;
        #1 chk("multi stall", 1'b0, store_stall);
        chk("multi ready", 1'b1, issue_ready);
        @(posedge sys_clk);
        #1 issue_valid = 1'b0;
        wait_done(n);
        run(mk(itm_pkg::ITM_EA_DREG, itm_pkg::ITM_EA_PREDEC, 2'h0, 0, 0, 0), 10'h011, 0, n);
        chk_n("after multi wait", 0, n);
    endtask

    task automatic t_unsup;
        issue = mk(itm_pkg::ITM_EA_IMM, itm_pkg::ITM_EA_DISP16, 2'h1, 0, 0, 0);
        issue_valid = 1'b1;
        #1 chk("unsupported", 1'b1, unsupported);
        repeat (3) @(posedge sys_clk);
        #1 chk("busy", 1'b0, busy);
        issue_valid = 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Two reset cycles, then each scenario in turn.
    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_reset();
        t_moves();
        t_misalign();
        t_stall();
        t_unsup();
        tally_and_finish();
    end
endmodule // tb_itm_timing

`default_nettype wire
